// [logic/agc_signal_level_loop.sv]
//Behaviour
// - control bit 4 clear selects signal-level mode
// - power is I squared plus Q squared
// - average 1-16384 samples, update every 1-4096
// - average length is ratio times 1..4
// - 12-bit decimation register, ratio 1..4096
// - one first-order CIC with snapshot FIFO
// - pre-CIC right shift 0..14, 4-bit field
// - log2 then halve for rms
// - error is full-scale rms minus request level minus rms
// - second-order loop filter, poles 1 and P
// - K and P are 8-bit fractions
// - loop output exponentiated to linear gain
// - fine 8-bit multiply then coarse 4-bit shift
// - 19-bit output truncated, fed back as power
module agc_signal_level_loop #(
   parameter int CHAN       = 0,
   parameter int FIFO_DEPTH = 4
) (
   input  logic        clk,
   input  logic        rst,
   input  logic        ce,
   input  logic [7:0]  awaddr,
   input  logic        awvalid,
   output logic        awready,
   input  logic [31:0] wdata,
   input  logic [3:0]  wstrb,
   input  logic        wvalid,
   output logic        wready,
   output logic [1:0]  bresp,
   output logic        bvalid,
   input  logic        bready,
   input  logic [7:0]  araddr,
   input  logic        arvalid,
   output logic        arready,
   output logic [31:0] rdata,
   output logic [1:0]  rresp,
   output logic        rvalid,
   input  logic        rready,
   input  logic [15:0] inI,
   input  logic [15:0] inQ,
   input  logic        inValid,
   output logic        inReady,
   output logic [15:0] outI,
   output logic [15:0] outQ,
   output logic        outValid,
   input  logic        outReady
);
   localparam int AW = agc_pkg::ACC_W;
   localparam int PW = agc_pkg::POW_W;

   if (CHAN < 0 || CHAN > 1) begin : g_chk
      $error("CHAN must be 0 or 1");
   end

   typedef struct packed {
      logic [15:0]              ctrlA;
      logic [15:0]              reqA;
      logic [15:0]              ctrlB;
      logic [15:0]              reqB;
      logic [7:0]               gainK;
      logic [7:0]               poleP;
      logic [7:0]               avgA;
      logic [7:0]               avgB;
      logic [11:0]              decA;
      logic [11:0]              decB;
      logic                     awHave;
      logic [7:0]               awAddr;
      logic                     wHave;
      logic [31:0]              wData;
      logic [3:0]               wStrb;
      logic                     bValid;
      logic [1:0]               bResp;
      logic                     rValid;
      logic [31:0]              rData;
      logic [1:0]               rResp;
      logic                     pwV;
      logic [PW-1:0]            pw;
      logic [AW-1:0]            acc;
      logic [11:0]              cnt;
      logic [3:0][AW-1:0]       hist;
      logic                     decV;
      logic [AW-1:0]            decPow;
      logic signed [23:0]       vSt;
      logic signed [31:0]       gAcc;
   } agc_state_t;

   localparam agc_state_t RST_ST = '{
      ctrlA: agc_pkg::RST_CTRL, ctrlB: agc_pkg::RST_CTRL,
      reqA: agc_pkg::RST_REQ, reqB: agc_pkg::RST_REQ,
      gainK: agc_pkg::RST_K, poleP: agc_pkg::RST_P,
      avgA: agc_pkg::RST_AVG, avgB: agc_pkg::RST_AVG,
      decA: agc_pkg::RST_DEC, decB: agc_pkg::RST_DEC,
      default: '0};

   agc_state_t         st;
   agc_state_t         next_st;
   logic [15:0]        ctrl;
   logic [15:0]        req;
   logic [7:0]         avg;
   logic [11:0]        dec;
   logic [3:0]         shiftAmt;
   logic [1:0]         mult;
   logic signed [9:0]  gl;
   logic signed [9:0]  glEff;
   logic [3:0]         coarse;
   logic [7:0]         fine;
   logic signed [18:0] scI;
   logic signed [18:0] scQ;
   logic signed [18:0] clI;
   logic signed [18:0] clQ;
   logic signed [18:0] srcI;
   logic signed [18:0] srcQ;
   logic signed [37:0] sqI;
   logic signed [37:0] sqQ;
   logic [18:0]        mask;
   logic [PW-1:0]      pwNow;
   logic               take;
   logic               fifoReady;
   logic [31:0]        fifoOut;
   logic [AW-1:0]      accNext;
   logic               decNow;
   logic [5:0]         lead;
   logic [AW-1:0]      norm;
   logic [5:0]         frac;
   logic [10:0]        rms;
   logic signed [13:0] errV;
   logic signed [32:0] pMul;
   logic signed [32:0] kMul;
   logic signed [23:0] vNext;
   logic signed [33:0] gSum;
   logic signed [31:0] gNext;
   logic [31:0]        statusWord;

   function automatic logic signed [18:0] scale(
      input logic signed [15:0] x,
      input logic [3:0]         c,
      input logic [7:0]         f);
      logic signed [24:0] p;
      logic signed [39:0] w;
      p = x * $signed({1'b0, f});
      w = 40'(p) <<< c;
      w = w >>> 15;
      // saturate rather than wrap at the 19-bit boundary
      if (w[39:18] != {22{w[39]}}) begin
         return w[39] ? 19'sh4_0000 : 19'sh3_ffff;
      end
      return w[18:0];
   endfunction

   function automatic logic reg_read(input logic [7:0] ix,
                                     output logic [31:0] v);
      v = '0;
      reg_read = 1'b1;
      case (ix)
         agc_pkg::IDX_A_CTRL: v[15:0] = st.ctrlA;
         agc_pkg::IDX_A_REQ:  v[15:0] = st.reqA;
         agc_pkg::IDX_K:      v[7:0]  = st.gainK;
         agc_pkg::IDX_P:      v[7:0]  = st.poleP;
         agc_pkg::IDX_A_AVG:  v[7:0]  = st.avgA;
         agc_pkg::IDX_A_DEC:  v[11:0] = st.decA;
         agc_pkg::IDX_B_CTRL: v[15:0] = st.ctrlB;
         agc_pkg::IDX_B_REQ:  v[15:0] = st.reqB;
         agc_pkg::IDX_B_AVG:  v[7:0]  = st.avgB;
         agc_pkg::IDX_B_DEC:  v[11:0] = st.decB;
         agc_pkg::IDX_STATUS: v       = statusWord;
         default:             reg_read = 1'b0;
      endcase
   endfunction

   assign ctrl = (CHAN == 1) ? st.ctrlB : st.ctrlA;
   assign req  = (CHAN == 1) ? st.reqB : st.reqA;
   assign avg  = (CHAN == 1) ? st.avgB : st.avgA;
   assign dec  = (CHAN == 1) ? st.decB : st.decA;
   assign mult = avg[agc_pkg::AVG_MULT +: 2];
   // values above 14 are clamped, the field is otherwise free
   assign shiftAmt = (avg[agc_pkg::AVG_SHIFT +: 4] > agc_pkg::SHIFT_MAX) ?
                     agc_pkg::SHIFT_MAX : avg[agc_pkg::AVG_SHIFT +: 4];

   // log gain in 1/64-bit steps; bypass forces unity gain
   assign gl     = st.gAcc[17:8];
   assign glEff  = ctrl[agc_pkg::CTRL_BYPASS] ? 10'sh000 : gl;
   assign coarse = glEff[9:6] ^ 4'h8;
   // linear mantissa stands in for 2^frac
   assign fine   = {1'b1, glEff[5:0], 1'b0};
   assign scI    = scale($signed(inI), coarse, fine);
   assign scQ    = scale($signed(inQ), coarse, fine);

   assign mask = ~((19'h0_0001 << agc_pkg::drop_bits(
                 ctrl[agc_pkg::CTRL_WIDTH +: 3])) - 19'h0_0001);
   assign clI  = $signed(scI & mask);
   assign clQ  = $signed(scQ & mask);
   // clip mode regulates truncation error instead of level
   assign srcI = ctrl[agc_pkg::CTRL_MODE] ? scI - clI : scI;
   assign srcQ = ctrl[agc_pkg::CTRL_MODE] ? scQ - clQ : scQ;
   assign sqI  = srcI * srcI;
   assign sqQ  = srcQ * srcQ;
   assign pwNow = $unsigned(sqI) + $unsigned(sqQ);

   assign take    = inValid && fifoReady;
   assign inReady = fifoReady;
   assign accNext = st.acc + AW'(st.pw);
   assign decNow  = st.cnt == dec;

   always_comb begin
      lead = '0;
      for (int b = 0; b < AW; b++) begin
         if (st.decPow[b]) begin
            lead = 6'(b);
         end
      end
   end

   assign norm  = st.decPow << (6'(AW - 1) - lead);
   assign frac  = norm[AW-2 -: 6];
   assign rms   = 11'({lead, frac} >> 1);
   assign errV  = $signed(agc_pkg::FS_RMS - {6'h00, req[7:0]}
                          - {3'h0, rms});
   assign pMul  = $signed({1'b0, st.poleP}) * st.vSt;
   assign kMul  = $signed({1'b0, st.gainK}) * st.vSt;
   assign vNext = errV + 24'(pMul >>> 8);
   assign gSum  = 34'(st.gAcc) + 34'(kMul);
   assign gNext = (gSum > agc_pkg::GAIN_HI) ? 32'(agc_pkg::GAIN_HI) :
                  (gSum < agc_pkg::GAIN_LO) ? 32'(agc_pkg::GAIN_LO) :
                  32'(gSum);
   assign statusWord = {5'h00, rms, {6{gl[9]}}, gl};

   assign awready = ce && !st.awHave && !st.bValid;
   assign wready  = ce && !st.wHave && !st.bValid;
   assign arready = ce && !st.rValid;
   assign bvalid  = st.bValid;
   assign bresp   = st.bResp;
   assign rvalid  = st.rValid;
   assign rdata   = st.rData;
   assign rresp   = st.rResp;

   always_comb begin
      logic [7:0]  wIdx;
      logic [31:0] old;
      logic [31:0] merged;
      logic [31:0] rv;
      logic        hit;
      logic        rHit;
      wIdx   = {2'b00, st.awAddr[7:2]};
      old    = '0;
      merged = '0;
      rv     = '0;
      hit    = 1'b0;
      rHit   = 1'b0;
      next_st = st;
      if (awvalid && awready) begin
         next_st.awHave = 1'b1;
         next_st.awAddr = awaddr;
      end
      if (wvalid && wready) begin
         next_st.wHave = 1'b1;
         next_st.wData = wdata;
         next_st.wStrb = wstrb;
      end
      if (st.awHave && st.wHave) begin
         hit = reg_read(wIdx, old);
         for (int b = 0; b < 4; b++) begin
            merged[8*b +: 8] = st.wStrb[b] ? st.wData[8*b +: 8]
                                           : old[8*b +: 8];
         end
         case (wIdx)
            agc_pkg::IDX_A_CTRL: next_st.ctrlA = merged[15:0];
            agc_pkg::IDX_A_REQ:  next_st.reqA  = merged[15:0];
            agc_pkg::IDX_K:      next_st.gainK = merged[7:0];
            agc_pkg::IDX_P:      next_st.poleP = merged[7:0];
            agc_pkg::IDX_A_AVG:  next_st.avgA  = merged[7:0];
            agc_pkg::IDX_A_DEC:  next_st.decA  = merged[11:0];
            agc_pkg::IDX_B_CTRL: next_st.ctrlB = merged[15:0];
            agc_pkg::IDX_B_REQ:  next_st.reqB  = merged[15:0];
            agc_pkg::IDX_B_AVG:  next_st.avgB  = merged[7:0];
            agc_pkg::IDX_B_DEC:  next_st.decB  = merged[11:0];
            default: ;
         endcase
         next_st.awHave = 1'b0;
         next_st.wHave  = 1'b0;
         next_st.bValid = 1'b1;
         next_st.bResp  = hit ? agc_pkg::RESP_OKAY : agc_pkg::RESP_SLVERR;
      end else if (st.bValid && bready) begin
         next_st.bValid = 1'b0;
      end
      if (arvalid && arready) begin
         rHit = reg_read({2'b00, araddr[7:2]}, rv);
         next_st.rData  = rv;
         next_st.rResp  = rHit ? agc_pkg::RESP_OKAY : agc_pkg::RESP_SLVERR;
         next_st.rValid = 1'b1;
      end else if (st.rValid && rready) begin
         next_st.rValid = 1'b0;
      end

      // power sample, pre-attenuated ahead of the integrator
      next_st.pwV = take;
      if (take) begin
         next_st.pw = pwNow >> shiftAmt;
      end
      next_st.decV = 1'b0;
      if (st.pwV) begin
         next_st.acc = accNext;
         if (decNow) begin
            // comb spans mult+1 updates: ratio times 1..4 samples
            next_st.cnt    = '0;
            next_st.decV   = 1'b1;
            next_st.decPow = accNext - st.hist[mult];
            next_st.hist   = {st.hist[2:0], accNext};
         end else begin
            next_st.cnt = st.cnt + 12'h001;
         end
      end
      // filter state moves only on an update sample
      if (st.decV) begin
         next_st.vSt  = vNext;
         next_st.gAcc = gNext;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= RST_ST;
      end else if (ce) begin
         st <= next_st;
      end
   end

   agc_fifo #(
      .WIDTH (32),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst      (rst),
      .ce       (ce),
      .inData   ({clI[18:3], clQ[18:3]}),
      .inValid  (inValid),
      .inReady  (fifoReady),
      .outData  (fifoOut),
      .outValid (outValid),
      .outReady (outReady)
   );

   assign outI = fifoOut[31:16];
   assign outQ = fifoOut[15:0];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_dec_take;
      ce && st.pwV && decNow;
   endsequence

   sequence s_no_update;
      !(ce && st.decV);
   endsequence

   a_mode_source: assert property (
      !ctrl[agc_pkg::CTRL_MODE] |-> srcI == scI && srcQ == scQ)
      else $error("level mode must use unclipped samples");

   // full-width squares: a self-sized product would keep only 19 bits
   a_power_shift: assert property (
      take |=> st.pwV && st.pw == ($past($unsigned(38'(srcI) * 38'(srcI))
         + $unsigned(38'(srcQ) * 38'(srcQ))) >> $past(shiftAmt)))
      else $error("power sample wrong");

   a_shift_cap: assert property (
      shiftAmt <= agc_pkg::SHIFT_MAX)
      else $error("shift above 14");

   a_dec_period: assert property (
      s_dec_take |=> st.decV && st.cnt == 12'h000)
      else $error("update not issued at ratio");

   a_comb_span: assert property (
      s_dec_take |=> st.decPow == $past(accNext) - $past(st.hist[mult]))
      else $error("comb output wrong");

   a_error_term: assert property (
      st.decV |-> int'(errV) == int'(agc_pkg::FS_RMS) - int'(req[7:0])
         - int'(rms))
      else $error("error term wrong");

   a_loop_step: assert property (
      ce && st.decV |=> st.vSt == $past(vNext)
         && st.gAcc == $past(gNext))
      else $error("loop filter step wrong");

   a_gain_hold: assert property (
      s_no_update |=> $stable(st.gAcc) && $stable(st.vSt))
      else $error("gain moved between updates");

   a_gain_range: assert property (
      34'(st.gAcc) <= agc_pkg::GAIN_HI && 34'(st.gAcc) >= agc_pkg::GAIN_LO)
      else $error("gain out of range");

   a_out_trunc: assert property (
      take |-> (clI & ~mask) == 19'h0_0000 && (clQ & ~mask) == 19'h0_0000)
      else $error("output not truncated");
endmodule

// [common/agc_pkg.sv]
package agc_pkg;
   // register indexes; byte address is four times the index
   localparam logic [7:0] IDX_A_CTRL = 8'h0a;
   localparam logic [7:0] IDX_A_REQ  = 8'h0b;
   localparam logic [7:0] IDX_K      = 8'h0e;
   localparam logic [7:0] IDX_P      = 8'h0f;
   localparam logic [7:0] IDX_A_AVG  = 8'h10;
   localparam logic [7:0] IDX_A_DEC  = 8'h11;
   localparam logic [7:0] IDX_B_CTRL = 8'h12;
   localparam logic [7:0] IDX_B_REQ  = 8'h14;
   localparam logic [7:0] IDX_B_AVG  = 8'h18;
   localparam logic [7:0] IDX_B_DEC  = 8'h19;
   localparam logic [7:0] IDX_STATUS = 8'h1c;

   // field positions
   localparam int CTRL_BYPASS = 0;
   localparam int CTRL_MODE   = 4;
   localparam int CTRL_WIDTH  = 5;
   localparam int AVG_MULT    = 0;
   localparam int AVG_SHIFT   = 4;
   localparam int REQ_LEVEL   = 0;

   // reset values
   localparam logic [15:0] RST_CTRL = 16'h0000;
   localparam logic [15:0] RST_REQ  = 16'h0000;
   localparam logic [7:0]  RST_K    = 8'h00;
   localparam logic [7:0]  RST_P    = 8'h00;
   localparam logic [7:0]  RST_AVG  = 8'h00;
   localparam logic [11:0] RST_DEC  = 12'h000;

   localparam logic [3:0] SHIFT_MAX = 4'he;
   localparam int POW_W = 38;
   localparam int ACC_W = 40;
   // full-scale rms in 1/64-bit log units
   localparam logic [13:0] FS_RMS = 14'h04a0;
   localparam logic signed [33:0] GAIN_HI = 34'sh0_0001_ffff;
   localparam logic signed [33:0] GAIN_LO = -34'sh0_0002_0000;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // low bits removed for output width codes 4,5,6,7,8,10,12,16
   function automatic logic [4:0] drop_bits(input logic [2:0] code);
      case (code)
         3'h0: return 5'h0f;
         3'h1: return 5'h0e;
         3'h2: return 5'h0d;
         3'h3: return 5'h0c;
         3'h4: return 5'h0b;
         3'h5: return 5'h09;
         3'h6: return 5'h07;
         default: return 5'h03;
      endcase
   endfunction
endpackage

// [logic/agc_fifo.sv]
module agc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input  logic             clk,
   input  logic             rst,
   input  logic             ce,
   input  logic [WIDTH-1:0] inData,
   input  logic             inValid,
   output logic             inReady,
   output logic [WIDTH-1:0] outData,
   output logic             outValid,
   input  logic             outReady
);
   localparam int PW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("DEPTH must be a power of two, at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wp;
      logic [PW-1:0]               rp;
      logic [PW:0]                 cnt;
   } agc_fifo_t;

   agc_fifo_t st;
   agc_fifo_t next_st;
   logic      push;
   logic      pop;

   assign inReady  = ce && st.cnt != (PW+1)'(DEPTH);
   assign outValid = ce && st.cnt != '0;
   assign outData  = st.mem[st.rp];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wp] = inData;
         next_st.wp = st.wp + PW'(1);
      end
      if (pop) begin
         next_st.rp = st.rp + PW'(1);
      end
      next_st.cnt = st.cnt + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end
endmodule

// [verification/agc_rake_sink.sv]
module agc_rake_sink (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        stall,
   input  wire logic [15:0] outI,
   input  wire logic [15:0] outQ,
   input  wire logic        outValid,
   output logic             outReady
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] got[$];

   // a busy receiver simply withholds ready; nothing is lost upstream
   assign outReady = !stall;

   always @(posedge clk) begin
      if (rst) begin
         got.delete();
      end else if (outValid && outReady) begin
         got.push_back({outI, outQ});
      end
   end
endmodule

// [verification/agc_signal_level_loop_test.sv]
module agc_signal_level_loop_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WID[8] = '{4, 5, 6, 7, 8, 10, 12, 16};
   localparam logic [7:0] RIDX[10] = '{agc_pkg::IDX_A_CTRL,
      agc_pkg::IDX_A_REQ, agc_pkg::IDX_K, agc_pkg::IDX_P,
      agc_pkg::IDX_A_AVG, agc_pkg::IDX_A_DEC, agc_pkg::IDX_B_CTRL,
      agc_pkg::IDX_B_REQ, agc_pkg::IDX_B_AVG, agc_pkg::IDX_B_DEC};
   localparam logic [31:0] RMSK[10] = '{32'h0000_ffff, 32'h0000_ffff,
      32'h0000_00ff, 32'h0000_00ff, 32'h0000_00ff, 32'h0000_0fff,
      32'h0000_ffff, 32'h0000_ffff, 32'h0000_00ff, 32'h0000_0fff};
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic [7:0]  awaddr = 8'h00;
   logic        awvalid = 1'b0;
   logic        awready;
   logic        wready;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0]  wstrb = 4'hf;
   logic        wvalid = 1'b0;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready = 1'b0;
   logic [7:0]  araddr = 8'h00;
   logic        arvalid = 1'b0;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready = 1'b0;
   logic [15:0] inI = 16'h0000;
   logic [15:0] inQ = 16'h0000;
   logic        inValid = 1'b0;
   logic        inReady;
   logic [15:0] outI;
   logic [15:0] outQ;
   logic        outValid;
   logic        outReady;
   logic        stall = 1'b0;
   int          fail_count = 0;
   int          checked = 0;

   always #2 clk = ~clk;

   agc_signal_level_loop #(.CHAN(0), .FIFO_DEPTH(4)) u_agc_signal_level_loop (
      .clk(clk), .rst(rst), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .inI(inI), .inQ(inQ), .inValid(inValid), .inReady(inReady),
      .outI(outI), .outQ(outQ), .outValid(outValid),
      .outReady(outReady));

   agc_rake_sink u_agc_rake_sink (
      .clk(clk), .rst(rst), .stall(stall), .outI(outI), .outQ(outQ),
      .outValid(outValid), .outReady(outReady));

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic hang(input string name);
      fail_count++;
      $display("[ERR] %s expected answer seen none", name);
      end_sim();
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                     output logic [1:0] resp);
      int n;
      @(posedge clk);
      awaddr <= {idx[5:0], 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      resp = bresp;
      bready <= 1'b0;
      if (n == 50) hang("bvalid");
   endtask

   task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                     output logic [1:0] resp);
      int n;
      @(posedge clk);
      araddr <= {idx[5:0], 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
      if (n == 50) hang("rvalid");
   endtask

   task automatic wr_ok(input logic [7:0] idx, input logic [31:0] d);
      logic [1:0] r;
      wr(idx, d, r);
      check("bresp", {30'h0, r}, {30'h0, agc_pkg::RESP_OKAY});
   endtask

   task automatic push(input logic [15:0] i, input logic [15:0] q);
      int n;
      @(posedge clk);
      inI <= i;
      inQ <= q;
      inValid <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (inReady) break;
      end
      inValid <= 1'b0;
      if (n == 50) hang("inReady");
   endtask

   task automatic pull(output logic [31:0] v);
      int n;
      for (n = 0; n < 50 && u_agc_rake_sink.got.size() == 0; n++) begin
         @(posedge clk);
      end
      if (n < 50) begin
         v = u_agc_rake_sink.got.pop_front();
      end else begin
         hang("outValid");
      end
   endtask

   task automatic do_reset();
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask

   initial begin
      logic [31:0]        v;
      logic [1:0]         r;
      logic signed [15:0] e;
      logic [15:0]        m;
      int                 n;
      do_reset();
      for (int k = 0; k < 10; k++) begin
         rd(RIDX[k], v, r);
         check("reset value", v, 32'h0000_0000);
         wr_ok(RIDX[k], 32'h5a5a_a5a5);
         rd(RIDX[k], v, r);
         check("readback", v, 32'h5a5a_a5a5 & RMSK[k]);
         wr_ok(RIDX[k], 32'h0000_0000);
      end
      wr(8'h13, 32'h0000_1234, r);
      check("unmapped bresp", {30'h0, r}, {30'h0, agc_pkg::RESP_SLVERR});
      rd(8'h13, v, r);
      check("unmapped rdata", v, 32'h0000_0000);
      check("unmapped rresp", {30'h0, r}, {30'h0, agc_pkg::RESP_SLVERR});
      // bypass keeps unity gain so only truncation shows
      for (int c = 0; c < 8; c++) begin
         wr_ok(agc_pkg::IDX_A_CTRL, 32'(c << 5) | 32'h0000_0001);
         push(16'h7ff8, 16'h8008);
         pull(v);
         m = 16'hffff << (16 - WID[c]);
         e = $signed(16'h7ff8) >>> 3;
         check("width I", {16'h0, v[31:16]}, {16'h0, e & m});
         e = $signed(16'h8008) >>> 3;
         check("width Q", {16'h0, v[15:0]}, {16'h0, e & m});
      end
      stall <= 1'b1;
      inValid <= 1'b1;
      inI <= 16'h0100;
      inQ <= 16'h0000;
      n = 0;
      repeat (20) begin
         @(posedge clk);
         if (inReady) begin
            n++;
            inI <= 16'(16'h0100 + 16'((n) * 8));
         end
      end
      inValid <= 1'b0;
      check("fifo fill", 32'(n), 32'd4);
      check("in refused", {31'h0, inReady}, 32'h0000_0000);
      stall <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         pull(v);
         check("drain I", {16'h0, v[31:16]}, 32'(16'h0020 + k));
      end
      wr_ok(agc_pkg::IDX_A_CTRL, 32'h0000_00e0);
      wr_ok(agc_pkg::IDX_A_DEC, 32'h0000_0fff);
      wr_ok(agc_pkg::IDX_K, 32'h0000_00ff);
      for (int k = 0; k < 8; k++) begin
         push(16'h0400, 16'h0400);
         pull(v);
         check("held gain", {16'h0, v[31:16]}, 32'h0000_0080);
      end
      // clock enable low must drop awready, arready, inReady and outValid
      ce <= 1'b0;
      repeat (2) @(posedge clk);
      check("ce freeze", {28'h0, awready, arready, inReady, outValid},
            32'h0000_0000);
      ce <= 1'b1;
      do_reset();
      wr_ok(agc_pkg::IDX_A_CTRL, 32'h0000_00e0);
      wr_ok(agc_pkg::IDX_A_AVG, 32'h0000_0011);
      wr_ok(agc_pkg::IDX_A_REQ, 32'h0000_0000);
      wr_ok(agc_pkg::IDX_K, 32'h0000_00ff);
      wr_ok(agc_pkg::IDX_P, 32'h0000_0080);
      push(16'h0400, 16'h0400);
      pull(v);
      check("first gain", {16'h0, v[31:16]}, 32'h0000_0080);
      for (int k = 0; k < 40; k++) begin
         push(16'h0400, 16'h0400);
         pull(v);
      end
      // weak input under a full-scale target must pull gain upward
      check("gain grew", {31'h0, $signed(v[31:16]) > 16'sh0080},
            32'h0000_0001);
      rd(agc_pkg::IDX_STATUS, v, r);
      check("status rresp", {30'h0, r}, {30'h0, agc_pkg::RESP_OKAY});
      check("status gain", {31'h0, $signed(v[15:0]) > 16'sh0000},
            32'h0000_0001);
      end_sim();
   end
endmodule
